// ==== logic/ref_cfg_pkg.sv ====
// Shared constants and types for the reference input configuration block
package ref_cfg_pkg;

	// Clock rate and derived time bases
	localparam int unsigned clk_period_ns = 10;
	localparam int unsigned ns_per_ms = 1000000;

	// Drop delay choices, each in its own printed unit
	localparam int unsigned drop_short_ms = 10;
	localparam int unsigned drop_mid_ms = 50;
	localparam real drop_long_s = 2.5;
	localparam int unsigned drop_min_cycles = 1;
	localparam int unsigned drop_short_cycles =
		drop_short_ms * ns_per_ms / clk_period_ns;
	localparam int unsigned drop_mid_cycles =
		drop_mid_ms * ns_per_ms / clk_period_ns;
	localparam int unsigned drop_long_cycles =
		$rtoi(drop_long_s * 1.0e9 / clk_period_ns);

	// Register indices; byte address is four times the index
	localparam logic [5:0] idx_fault_history = 6'h07;
	localparam logic [5:0] idx_live_status = 6'h08;
	localparam logic [5:0] idx_input_setup = 6'h0a;
	localparam logic [5:0] idx_drop_delay = 6'h0b;
	localparam logic [5:0] idx_accept_delay = 6'h0c;
	localparam logic [5:0] idx_freeze = 6'h0d;
	localparam logic [5:0] idx_rate_high = 6'h10;
	localparam logic [5:0] idx_rate_low = 6'h11;

	// Values after reset
	localparam logic [7:0] input_setup_reset = 8'h00;
	localparam logic [7:0] drop_delay_reset = 8'haa;
	localparam logic [7:0] accept_delay_reset = 8'h01;
	localparam logic [7:0] freeze_reset = 8'h00;
	localparam logic [15:0] unit_rate_reset = 16'h61a8;

	// Field positions
	localparam int unsigned halve_bit = 0;
	localparam int unsigned diff_bit = 4;
	localparam int unsigned history_scm_bit = 1;
	localparam int unsigned history_cfm_bit = 2;
	localparam int unsigned history_gst_bit = 3;

	// Freeze register codes
	localparam logic [7:0] freeze_lock_code = 8'h01;
	localparam logic [7:0] freeze_open_code = 8'h00;

	// Guard soak state machine
	typedef enum logic [1:0] {
		guard_qualified,
		guard_dropping,
		guard_disqualified,
		guard_accepting
	} guard_state_type;

endpackage

// ==== logic/soak_counter.sv ====
// Cycle counter that times one guard soak interval
`timescale 1ns/1ns
module soak_counter #(
	parameter int unsigned width = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [width-1:0] target,
	output logic expired,
	output logic [width-1:0] elapsed
);

	logic [width-1:0] count;

	// Counts while run is high; dropping run restarts the interval
	always_ff @(posedge clk) begin
		if (rst || !run || expired) begin
			count <= '0;
		end else begin
			count <= count + {{(width-1){1'b0}}, 1'b1};
		end
	end

	// A target of zero would never match, so it behaves as one
	assign expired = run &&
		((count == target - {{(width-1){1'b0}}, 1'b1}) ||
		(target == '0));
	assign elapsed = count;

endmodule

// ==== logic/reference_input_config.sv ====
// Reference input setup, guard soak timing and status freeze registers
//
// Notes on behaviour
// R1 - Halving bit set: reference reaches the phase loop divided by two.
// R2 - Halving bit clear: reference reaches the phase loop undivided.
// R3 - Software programs frequency settings for half the rate while halving.
// R4 - Differential bit set: reference taken across positive and negative pins.
// R5 - Differential bit clear: reference taken from positive pin alone.
// R6 - Drop field picks minimum, 10 ms, 50 ms or 2.5 s; reset is 50 ms.
// R7 - Drop delay starts when coarse frequency or single cycle fault appears.
// R8 - Requalify only after accept delay once both fault inputs are clear.
// R9 - Accept field is 2, 4, 6 or 8 times the drop delay; reset four.
// R10 - Writing 0x01 to freeze register stops hold-until-read status updates.
// R11 - Writing 0x00 to freeze register resumes hold-until-read status updates.
// R12 - The 16-bit base rate is an unsigned frequency in hertz.
// R13 - Software loads only supported base rates; reset selects 25 kHz.
// R14 - Multi-byte registers keep the high byte at the lower address.
// R15 - Guard failure flag rises whenever the drop soak timer expires.
// R16 - A fault during the accept delay abandons requalification.
`timescale 1ns/1ns
module reference_input_config
	import ref_cfg_pkg::*;
#(
	parameter int unsigned drop_min = drop_min_cycles,
	parameter int unsigned drop_short = drop_short_cycles,
	parameter int unsigned drop_mid = drop_mid_cycles,
	parameter int unsigned drop_long = drop_long_cycles
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic ref_p,
	input wire logic ref_n,
	input wire logic cfm_fault,
	input wire logic scm_fault,
	output logic ref_to_pll,
	output logic diff_input_enable,
	output logic status_freeze,
	output logic [15:0] base_rate_value,
	output logic reference_qualified,
	output logic gst_expired
);

	logic ack;
	logic wr_take;
	logic rd_take;
	logic [5:0] idx;
	logic [7:0] input_setup;
	logic [7:0] drop_delay;
	logic [7:0] accept_delay;
	logic [7:0] freeze_value;
	logic [2:0] history;
	logic [2:0] next_history;
	logic [2:0] history_clear;
	logic [7:0] read_byte;
	logic ref_p_meta;
	logic ref_p_sync;
	logic ref_n_meta;
	logic ref_n_sync;
	logic sel_ref;
	logic sel_prev;
	logic sel_rise;
	logic div;
	logic next_div;
	logic halve;
	logic fault_any;
	guard_state_type state;
	logic timer_run;
	logic timer_expired;
	logic [31:0] timer_count;
	logic [31:0] drop_target;
	logic [31:0] accept_target;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// One wait state: a request is answered on the cycle after it appears
	assign idx = address[7:2];
	assign waitrequest = (read || write) && !ack;
	assign wr_take = write && ack && byteenable[0];
	assign rd_take = read && !ack;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= (read || write) && !ack;
		end
	end

	// Bus answer comes exactly one cycle after a request first appears
	sequence req_pending;
		(read || write) && waitrequest;
	endsequence
	a_bus_answer: assert property (req_pending |=> !waitrequest)
		else $error("bus request not answered after one wait state");

	// Writable configuration bytes; lane 0 carries the byte
	always_ff @(posedge clk) begin
		if (rst) begin
			input_setup <= input_setup_reset;
			drop_delay <= drop_delay_reset;
			accept_delay <= accept_delay_reset;
			freeze_value <= freeze_reset;
		end else if (wr_take) begin
			case (idx)
				idx_input_setup: input_setup <= writedata[7:0];
				idx_drop_delay: drop_delay <= writedata[7:0];
				idx_accept_delay: accept_delay <= writedata[7:0];
				idx_freeze: freeze_value <= writedata[7:0];
				default: ;
			endcase
		end
	end

	// Base rate kept as two bytes, high byte at the lower index
	always_ff @(posedge clk) begin
		if (rst) begin
			base_rate_value <= unit_rate_reset;
		end else if (wr_take && idx == idx_rate_high) begin
			base_rate_value[15:8] <= writedata[7:0]; // R14
		end else if (wr_take && idx == idx_rate_low) begin
			base_rate_value[7:0] <= writedata[7:0]; // R12 R14
		end
	end

	a_rate_high_byte: assert property ( // R14
		wr_take && idx == idx_rate_high |=>
		base_rate_value[15:8] == $past(writedata[7:0]) &&
		$stable(base_rate_value[7:0]))
		else $error("high rate byte not stored at lower index");
	a_rate_low_byte: assert property ( // R12
		wr_take && idx == idx_rate_low |=>
		base_rate_value == {$past(base_rate_value[15:8]),
		$past(writedata[7:0])})
		else $error("base rate not held as one binary value");

	// Freeze follows only the two defined codes; other values leave it
	always_ff @(posedge clk) begin
		if (rst) begin
			status_freeze <= 1'b0;
		end else if (wr_take && idx == idx_freeze) begin
			if (writedata[7:0] == freeze_lock_code) begin
				status_freeze <= 1'b1; // R10
			end else if (writedata[7:0] == freeze_open_code) begin
				status_freeze <= 1'b0; // R11
			end
		end
	end

	a_freeze_set: assert property ( // R10
		wr_take && idx == idx_freeze &&
		writedata[7:0] == freeze_lock_code |=> status_freeze)
		else $error("lock code did not freeze status");
	a_freeze_release: assert property ( // R11
		wr_take && idx == idx_freeze &&
		writedata[7:0] == freeze_open_code |=> !status_freeze)
		else $error("open code did not release status");

	// Hold-until-read history: set wins over the write-one clear
	assign history_clear = (wr_take && idx == idx_fault_history) ?
		{writedata[history_gst_bit], writedata[history_cfm_bit],
		writedata[history_scm_bit]} : 3'h0;

	always_comb begin
		next_history = history & ~history_clear;
		if (!status_freeze) begin
			next_history = next_history |
				{gst_expired, cfm_fault, scm_fault}; // R10
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			history <= 3'h0;
		end else begin
			history <= next_history;
		end
	end

	a_freeze_holds: assert property ( // R10
		status_freeze && history_clear == 3'h0 |=> $stable(history))
		else $error("frozen status changed without software clear");
	a_open_records: assert property ( // R11
		!status_freeze && scm_fault |=> history[0])
		else $error("open status missed a single cycle fault");

	// Read mux; unmapped indices read as zero
	always_comb begin
		case (idx)
			idx_fault_history: read_byte = {4'h0, history, 1'b0};
			idx_live_status: read_byte = {6'h00, timer_run,
				reference_qualified};
			idx_input_setup: read_byte = input_setup;
			idx_drop_delay: read_byte = drop_delay;
			idx_accept_delay: read_byte = accept_delay;
			idx_freeze: read_byte = freeze_value;
			idx_rate_high: read_byte = base_rate_value[15:8];
			idx_rate_low: read_byte = base_rate_value[7:0];
			default: read_byte = 8'h00;
		endcase
	end

	// Read data loads in the wait cycle so it stands when waitrequest drops
	always_ff @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (rd_take) begin
			readdata <= {24'h00_0000, read_byte};
		end
	end

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_p_meta <= 1'b0;
			ref_p_sync <= 1'b0;
			ref_n_meta <= 1'b0;
			ref_n_sync <= 1'b0;
		end else begin
			ref_p_meta <= ref_p;
			ref_p_sync <= ref_p_meta;
			ref_n_meta <= ref_n;
			ref_n_sync <= ref_n_meta;
		end
	end

	// Receiver select; sampling limits usable rate to under clk/2
	assign diff_input_enable = input_setup[diff_bit];
	assign halve = input_setup[halve_bit];

	always_ff @(posedge clk) begin
		if (rst) begin
			sel_ref <= 1'b0;
			sel_prev <= 1'b0;
		end else begin
			if (diff_input_enable) begin
				sel_ref <= ref_p_sync && !ref_n_sync; // R4
			end else begin
				sel_ref <= ref_p_sync; // R5
			end
			sel_prev <= sel_ref;
		end
	end

	a_diff_receive: assert property ( // R4
		diff_input_enable |=>
		sel_ref == ($past(ref_p_sync) && !$past(ref_n_sync)))
		else $error("differential input not taken across both pins");
	a_single_ended: assert property ( // R5
		!diff_input_enable |=> sel_ref == $past(ref_p_sync))
		else $error("single-ended input not taken from positive pin");

	// Divide by two toggles on each rising edge of the selected input
	assign sel_rise = sel_ref && !sel_prev;
	assign next_div = div ^ sel_rise;

	always_ff @(posedge clk) begin
		if (rst || !halve) begin
			div <= 1'b0;
		end else begin
			div <= next_div; // R1
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ref_to_pll <= 1'b0;
		end else if (halve) begin
			ref_to_pll <= next_div; // R1
		end else begin
			ref_to_pll <= sel_ref; // R2
		end
	end

	a_halve_toggle: assert property ( // R1
		halve && $past(halve) && sel_rise |=>
		ref_to_pll != $past(ref_to_pll))
		else $error("halved output missed a toggle on input edge");
	a_halve_hold: assert property ( // R1
		halve && $past(halve) && !sel_rise |=> $stable(ref_to_pll))
		else $error("halved output moved without an input edge");
	a_direct_path: assert property ( // R2
		!halve |=> ref_to_pll == $past(sel_ref))
		else $error("undivided path does not follow the input");

	// Drop delay selection and accept multiple of it
	always_comb begin
		case (drop_delay[1:0])
			2'b00: drop_target = 32'(drop_min); // R6
			2'b01: drop_target = 32'(drop_short); // R6
			2'b10: drop_target = 32'(drop_mid); // R6
			default: drop_target = 32'(drop_long); // R6
		endcase
	end

	// Product kept in 32 bits; eight times 2.5 s still fits
	always_comb begin
		case (accept_delay[1:0])
			2'b00: accept_target = {drop_target[30:0], 1'b0}; // R9
			2'b01: accept_target = {drop_target[29:0], 2'b00}; // R9
			2'b10: accept_target = {drop_target[29:0], 2'b00} +
				{drop_target[30:0], 1'b0}; // R9
			default: accept_target = {drop_target[28:0], 3'b000}; // R9
		endcase
	end

	a_accept_scale: assert property ( // R9
		accept_delay[1:0] == 2'b10 |-> accept_target == drop_target * 6)
		else $error("accept delay is not six drop delays");

	// Soak timer runs only while a delay is being timed
	assign fault_any = cfm_fault || scm_fault;
	assign timer_run = (state == guard_dropping) ||
		(state == guard_accepting);

	soak_counter #(
		.width(32)
	) soak (
		.clk(clk),
		.rst(rst),
		.run(timer_run),
		.target(state == guard_accepting ? accept_target : drop_target),
		.expired(timer_expired),
		.elapsed(timer_count)
	);

	// Guard soak state machine; a fault that clears early cancels the drop
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= guard_qualified;
		end else begin
			case (state)
				guard_qualified: begin
					if (fault_any) begin
						state <= guard_dropping; // R7
					end
				end
				guard_dropping: begin
					if (timer_expired) begin
						state <= guard_disqualified; // R6
					end else if (!fault_any) begin
						state <= guard_qualified;
					end
				end
				guard_disqualified: begin
					if (!fault_any) begin
						state <= guard_accepting; // R8
					end
				end
				guard_accepting: begin
					if (fault_any) begin
						state <= guard_disqualified; // R16
					end else if (timer_expired) begin
						state <= guard_qualified; // R8
					end
				end
				default: state <= guard_qualified;
			endcase
		end
	end

	// Registered status outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			gst_expired <= 1'b0;
			reference_qualified <= 1'b1;
		end else begin
			gst_expired <= (state == guard_dropping) &&
				timer_expired; // R15
			reference_qualified <= (state == guard_qualified) ||
				(state == guard_dropping && !timer_expired) ||
				(state == guard_accepting && !fault_any &&
				timer_expired);
		end
	end

	sequence drop_done;
		state == guard_dropping && timer_expired;
	endsequence
	a_drop_start: assert property ( // R7
		state == guard_qualified && fault_any |=>
		state == guard_dropping && timer_count == 32'h0)
		else $error("fault did not start the drop delay");
	a_drop_timing: assert property ( // R6
		drop_done |-> timer_count == drop_target - 32'h1)
		else $error("drop delay length differs from selection");
	a_gst_flag: assert property ( // R15
		drop_done |=> gst_expired && state == guard_disqualified)
		else $error("expired drop timer did not raise the flag");
	a_accept_gate: assert property ( // R8
		$rose(reference_qualified) && !$past(rst) |->
		$past(state) == guard_accepting &&
		$past(timer_count) == $past(accept_target) - 32'h1 &&
		!$past(fault_any))
		else $error("requalified before the accept delay ran out");
	a_requal_abort: assert property ( // R16
		state == guard_accepting && fault_any |=>
		state == guard_disqualified && !reference_qualified)
		else $error("fault during accept delay did not abort");

endmodule

// ==== bench/ref_source.sv ====
// Model of the external reference clock source at the input pins
`timescale 1ns/1ns
module ref_source #(
	parameter int unsigned half_cycles = 4
) (
	input wire logic clk,
	input wire logic run,
	input wire logic diff,
	input wire logic n_high,
	output logic ref_p,
	output logic ref_n
);
	int unsigned count = 0;
	logic level = 1'b0;

	// Square wave while running; parks low so no stray edge follows a stop
	always @(posedge clk) begin
		if (!run) begin
			count <= 0;
			level <= 1'b0;
		end else if (count == half_cycles - 1) begin
			count <= 0;
			level <= ~level;
		end else begin
			count <= count + 1;
		end
	end

	// Negative pin is held high by n_high, else the complement in differential use and grounded otherwise
	assign ref_p = level;
	assign ref_n = n_high | (diff & ~level);
endmodule

// ==== bench/tb_reference_input_config.sv ====
// Self-checking bench for the reference input configuration block
`timescale 1ns/1ns
module tb_reference_input_config;
	import ref_cfg_pkg::*;
	typedef struct {
		logic [5:0] idx;
		logic [7:0] wdata;
		logic [7:0] rst_val;
		logic [7:0] rd_val;
	} row_type;
	localparam int d_min = 1;
	localparam int d_short = 10;
	localparam int d_mid = 20;
	localparam int d_long = 40;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] be = 4'h1;
	logic [31:0] readdata;
	logic waitrequest;
	logic ref_p;
	logic ref_n;
	logic cfm = 1'b0;
	logic scm = 1'b0;
	logic run = 1'b0;
	logic diff_sel = 1'b0;
	logic n_high = 1'b0;
	logic ref_to_pll;
	logic diff_input_enable;
	logic status_freeze;
	logic [15:0] base_rate_value;
	logic reference_qualified;
	logic gst_expired;
	logic [7:0] rd;
	int n_mismatch = 0;
	int compares = 0;
	int dtab [4] = '{d_min, d_short, d_mid, d_long};
	// Reset, write, read back; last row is an unmapped index
	row_type rows [9] = '{
		'{6'h0a, 8'h11, 8'h00, 8'h11},
		'{6'h0b, 8'h03, 8'haa, 8'h03},
		'{6'h0c, 8'h02, 8'h01, 8'h02},
		'{6'h0d, 8'h5a, 8'h00, 8'h5a},
		'{6'h10, 8'h9c, 8'h61, 8'h9c},
		'{6'h11, 8'h40, 8'ha8, 8'h40},
		'{6'h07, 8'hff, 8'h00, 8'h00},
		'{6'h08, 8'hff, 8'h01, 8'h01},
		'{6'h3f, 8'hff, 8'h00, 8'h00}};

	always #5 clk = ~clk;

	ref_source #(.half_cycles(4)) src (.clk(clk), .run(run), .diff(diff_sel),
		.n_high(n_high), .ref_p(ref_p), .ref_n(ref_n));

	// Short drop counts keep the longest accept interval to a few hundred
	reference_input_config #(.drop_min(d_min), .drop_short(d_short),
		.drop_mid(d_mid), .drop_long(d_long)) uut (
		.clk(clk),
		.rst(rst),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(be),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.ref_p(ref_p),
		.ref_n(ref_n),
		.cfm_fault(cfm),
		.scm_fault(scm),
		.ref_to_pll(ref_to_pll),
		.diff_input_enable(diff_input_enable),
		.status_freeze(status_freeze),
		.base_rate_value(base_rate_value),
		.reference_qualified(reference_qualified),
		.gst_expired(gst_expired)
	);

	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check_val(string name, logic [15:0] exp, logic [15:0] got);
		compares++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask

	task automatic check_num(string name, int exp, int got);
		compares++;
		if (got != exp) begin
			$display("Error %s expected %0d seen %0d", name, exp, got);
			n_mismatch++;
		end
	endtask

	// One bus transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] idx,
		input logic [7:0] d);
		int n;
		n = 0;
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (waitrequest !== 1'b0) begin
			check_val("waitrequest", 16'h0, {15'h0, waitrequest});
			end_of_test();
		end
		// Read data and the write both complete at this edge
		rd = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clk);
	endtask

	// Counts edges until the qualified output reaches lvl
	task automatic wait_q(input logic lvl, input int exp, input logic gst);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (reference_qualified !== lvl && n < 2000);
		check_num("guard edges", exp, n);
		if (gst) begin
			check_val("gst pulse", 16'h1, {15'h0, gst_expired});
		end
		if (n == 2000) end_of_test();
		@(posedge clk);
	endtask

	// Eight source rises in a window; counts rises that reach the loop
	task automatic ref_mode(input logic h, d, nh, input int exp);
		int rises;
		logic last;
		rises = 0;
		bus(1'b1, idx_input_setup, {3'h0, d, 3'h0, h});
		check_val("diff enable", {15'h0, d},
			{15'h0, diff_input_enable});
		diff_sel <= d;
		n_high <= nh;
		repeat (8) @(posedge clk);
		last = ref_to_pll;
		run <= 1'b1;
		for (int i = 0; i < 80; i++) begin
			@(posedge clk);
			if (i == 63) run <= 1'b0;
			@(negedge clk);
			if (ref_to_pll === 1'b1 && last === 1'b0) rises++;
			last = ref_to_pll;
		end
		check_num("output rises", exp, rises);
		@(posedge clk);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_val("qualified", 16'h1, {15'h0, reference_qualified});
		check_val("freeze", 16'h0, {15'h0, status_freeze});
		check_val("base rate", 16'h61a8, base_rate_value);
		check_val("gst pulse", 16'h0, {15'h0, gst_expired});
		$display("Test reset done");
		foreach (rows[i]) begin
			bus(1'b0, rows[i].idx, 8'h00);
			check_val("reset value", {8'h0, rows[i].rst_val},
				{8'h0, rd});
			bus(1'b1, rows[i].idx, rows[i].wdata);
			bus(1'b0, rows[i].idx, 8'h00);
			check_val("read back", {8'h0, rows[i].rd_val},
				{8'h0, rd});
		end
		check_val("base rate", 16'h9c40, base_rate_value);
		check_val("freeze", 16'h0, {15'h0, status_freeze});
		be <= 4'h0;
		bus(1'b1, idx_rate_high, 8'h12);
		be <= 4'h1;
		check_val("masked write", 16'h9c40, base_rate_value);
		$display("Test registers done");
		ref_mode(1'b0, 1'b0, 1'b0, 8);
		ref_mode(1'b1, 1'b0, 1'b0, 4);
		ref_mode(1'b0, 1'b1, 1'b0, 8);
		ref_mode(1'b0, 1'b0, 1'b1, 8);
		ref_mode(1'b0, 1'b1, 1'b1, 0);
		ref_mode(1'b1, 1'b1, 1'b0, 4);
		$display("Test reference path done");
		// Every drop code with its own accept multiple, both fault sources
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, idx_drop_delay, 8'(k));
			bus(1'b1, idx_accept_delay, 8'(k));
			if (k % 2 == 0) begin
				cfm <= 1'b1;
			end else begin
				scm <= 1'b1;
			end
			wait_q(1'b0, dtab[k] + 1, 1'b1);
			cfm <= 1'b0;
			scm <= 1'b0;
			wait_q(1'b1, 2 * (k + 1) * dtab[k] + 1, 1'b0);
		end
		// A short fault inside the accept interval must restart it
		bus(1'b1, idx_drop_delay, 8'h01);
		bus(1'b1, idx_accept_delay, 8'h00);
		cfm <= 1'b1;
		wait_q(1'b0, d_short + 1, 1'b1);
		cfm <= 1'b0;
		repeat (5) @(posedge clk);
		scm <= 1'b1;
		@(posedge clk);
		scm <= 1'b0;
		wait_q(1'b1, 2 * d_short + 1, 1'b0);
		$display("Test guard timer done");
		bus(1'b1, idx_fault_history, 8'h0e);
		for (int f = 1; f >= 0; f--) begin
			bus(1'b1, idx_freeze, 8'(f));
			check_val("freeze", 16'(f), {15'h0, status_freeze});
			scm <= 1'b1;
			repeat (3) @(posedge clk);
			scm <= 1'b0;
			@(posedge clk);
			bus(1'b0, idx_fault_history, 8'h00);
			check_val("history", f ? 16'h0 : 16'h2, {8'h0, rd});
		end
		$display("Test freeze done");
		// A reset in mid-run must bring freeze, base rate, qualified and drop delay back
		bus(1'b1, idx_freeze, 8'h01);
		bus(1'b1, idx_rate_high, 8'h12);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_val("freeze", 16'h0, {15'h0, status_freeze});
		check_val("base rate", 16'h61a8, base_rate_value);
		check_val("qualified", 16'h1, {15'h0, reference_qualified});
		bus(1'b0, idx_drop_delay, 8'h00);
		check_val("reset value", 16'haa, {8'h0, rd});
		$display("Test mid-run reset done");
		end_of_test();
	end
endmodule
